// File: rtl/schrb_regbank.sv
// Host register bank of the clock synchronizer with parallel bus handshakes
`timescale 1ns/1ps
module schrb_regbank
	import schrb_pkg::*;
#(
	parameter logic [15:0] IDENTITY_CODE = 16'hA5C3, // Arbitrary value
	parameter logic [7:0] SILICON_REV = 8'h01, // Arbitrary value
	parameter logic [7:0] FIRMWARE_REV = 8'h01, // Arbitrary value
	parameter int READY_LEN = READY_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [2:0] host_bus_select_pins,
	input wire logic role_select_pin,
	input wire schrb_pkg::schrb_host_in_t host_in,
	input wire logic [REF_COUNT*16-1:0] ref_info_flat,
	output logic [7:0] data_out,
	output logic data_oe_n,
	output logic ready_out,
	output logic ready_oe_n,
	output logic [15:0] slave_phase_offset,
	output logic [3:0] fill_window_size,
	output logic [3:0] leak_window_multiple,
	output logic [5:0] activity_accumulator_size,
	output logic accumulator_bypass,
	output logic [5:0] alarm_raise_level,
	output logic [5:0] alarm_clear_level,
	output logic [10:0] free_oscillator_trim,
	output logic [9:0] reject_offset_limit,
	output logic [9:0] accept_offset_limit,
	output logic [5:0] accept_soak_seconds,
	output logic [3:0] reference_pointer
);
	import schrb_pkg::*;

	// Ready counter is eight bits wide
	if (READY_LEN < 1 || READY_LEN > 255) begin : g_len_check
		$error("READY_LEN out of range");
	end

	// ----------------------------------------
	// Access sequencing
	// ----------------------------------------
	typedef enum logic [1:0] {
		SCHRB_IDLE = 2'b00,
		SCHRB_BUSY = 2'b01,
		SCHRB_DONE = 2'b10
	} schrb_state_t;

	schrb_state_t state_q, state_d;
	logic [7:0] cnt_q, cnt_d;
	logic [6:0] alat_q;
	logic [7:0] hold_q;
	logic [6:0] hold_addr_q;
	logic hold_valid_q;
	logic [7:0] wbuf_q;
	logic [6:0] wbuf_addr_q;
	logic wbuf_valid_q;

	logic [15:0] phase_q;
	logic [3:0] fill_q, leak_q, ptr_q;
	logic [5:0] size_q, raise_q, clear_q, soak_q;
	logic [10:0] trim_q;
	logic [9:0] reject_q, accept_q;
	logic [7:0] dout_q;
	logic doe_n_q, rdy_q, rdy_oe_n_q;

	// ----------------------------------------
	// Mode decode and strobes
	// ----------------------------------------
	wire mode_mux = host_bus_select_pins == SCHRB_MODE_MUX;
	wire mode_strb = host_bus_select_pins == SCHRB_MODE_STROBE;
	wire mode_line = host_bus_select_pins == SCHRB_MODE_RWLINE;
	wire parallel = mode_mux | mode_strb | mode_line;
	wire sel = ~host_in.cs_n & parallel;
	// Line mode: wr_n low means write; select alone starts the access
	wire start_rd = mode_line ? host_in.wr_n : ~host_in.rd_n;
	wire start_wr = mode_line ? ~host_in.wr_n : ~host_in.wr_n;
	wire strobe = mode_line ? 1'b1 : (~host_in.rd_n | ~host_in.wr_n);
	wire go = sel & strobe & ~(mode_mux & host_in.ale);
	wire [6:0] addr = mode_mux ? alat_q : host_in.addr;
	wire is_wr = start_wr & ~(start_rd & ~mode_line);

	// ----------------------------------------
	// Multibyte decode
	// ----------------------------------------
	function automatic logic is_low_byte(input logic [6:0] a);
		return a == OFS_IDENTITY_LO || a == OFS_PHASE_LO ||
			a == OFS_TRIM_LO || a == OFS_REJECT_LO ||
			a == OFS_ACCEPT_LO || a == OFS_REF_INFO_LO;
	endfunction

	wire [6:0] addr_p1 = 7'(addr + 7'h01);
	wire [6:0] addr_m1 = 7'(addr - 7'h01);
	wire hi_byte = is_low_byte(addr_m1) && addr != 7'h00;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	schrb_ref_info_t info;
	wire [3:0] ptr_idx = 4'(ptr_q - REF_PTR_MIN);
	assign info = ref_info_flat[ptr_idx*16 +: 16];
	wire [15:0] info_word = {info.rate, info.offset};

	logic [15:0] live;
	always_comb begin
		live = 16'h0000;
		case (addr & 7'h7E)
			OFS_IDENTITY_LO: live = IDENTITY_CODE;
			OFS_SILICON_REV: live = {FIRMWARE_REV, SILICON_REV};
			OFS_ROLE_STATUS: live = {phase_q[7:0], 7'h00, role_select_pin};
			OFS_PHASE_HI: live = {4'h0, fill_q, phase_q[15:8]};
			OFS_LEAK_WIN: live = {2'b00, size_q, 4'h0, leak_q};
			OFS_RAISE_LVL: live = {2'b00, clear_q, 2'b00, raise_q};
			OFS_TRIM_LO: live = {5'h00, trim_q};
			OFS_REJECT_LO: live = {6'h00, reject_q};
			OFS_ACCEPT_LO: live = {6'h00, accept_q};
			OFS_SOAK: live = {4'h0, ptr_q, 2'b00, soak_q};
			OFS_REF_INFO_LO: live = info_word;
			default: live = 16'h0000;
		endcase
	end

	wire [7:0] live_byte = addr[0] ? live[15:8] : live[7:0];
	wire use_hold = hi_byte & hold_valid_q & hold_addr_q == addr;
	wire [7:0] rd_byte = use_hold ? hold_q : live_byte;
	// Phase low byte sits at an odd offset; its top byte is in the next word
	wire [7:0] hold_next = addr[0] ? phase_q[15:8] : live[15:8];

	// ----------------------------------------
	// Write checks
	// ----------------------------------------
	wire [7:0] wd = host_in.data;
	wire wr_top = hi_byte & wbuf_valid_q & wbuf_addr_q == addr;
	wire [9:0] wide10 = {wd[1:0], wbuf_q};
	wire size_ok = wd[5:0] >= raise_q;
	wire raise_ok = wd[5:0] > clear_q && wd[5:0] <= size_q;
	wire clear_ok = wd[5:0] < raise_q;
	wire reject_ok = wide10 > accept_q;
	wire accept_ok = wide10 < reject_q;
	wire ptr_ok = wd[3:0] >= REF_PTR_MIN && wd[3:0] <= REF_PTR_MAX &&
		wd[7:4] == 4'h0;
	wire commit = state_q == SCHRB_IDLE && go;
	wire do_wr = commit & is_wr;
	wire do_rd = commit & ~is_wr;

	// ----------------------------------------
	// Handshake state machine
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			SCHRB_IDLE: begin
				if (go) begin
					state_d = SCHRB_BUSY;
					cnt_d = 8'(READY_LEN);
				end
			end
			SCHRB_BUSY: begin
				if (cnt_q > 8'h01) begin
					cnt_d = 8'(cnt_q - 8'h01);
				end else begin
					state_d = SCHRB_DONE;
				end
			end
			SCHRB_DONE: begin
				// Host must release its select, or outside line mode its strobe, before next access
				if (~sel || (~mode_line && ~strobe)) begin
					state_d = SCHRB_IDLE;
				end
			end
			default: state_d = SCHRB_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q <= SCHRB_IDLE;
			cnt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Address latched in mux mode while ale is high
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			alat_q <= 7'h00;
		end else if (mode_mux && host_in.ale) begin
			alat_q <= host_in.data[6:0];
		end
	end

	// ----------------------------------------
	// Ready and data pins
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdy_q <= 1'b1;
			rdy_oe_n_q <= 1'b1;
		end else if (!sel) begin
			rdy_q <= 1'b1;
			rdy_oe_n_q <= 1'b1;
		end else if (mode_line) begin
			rdy_oe_n_q <= 1'b0;
			rdy_q <= state_d != SCHRB_DONE;
		end else begin
			rdy_oe_n_q <= 1'b0;
			rdy_q <= state_d == SCHRB_DONE || state_d == SCHRB_IDLE;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dout_q <= 8'h00;
			doe_n_q <= 1'b1;
		end else begin
			if (do_rd) begin
				dout_q <= rd_byte;
			end
			doe_n_q <= ~(sel && state_q != SCHRB_IDLE && ~is_wr &&
				(mode_line || ~host_in.rd_n));
		end
	end

	// ----------------------------------------
	// Holding registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hold_q <= 8'h00;
			hold_addr_q <= 7'h00;
			hold_valid_q <= 1'b0;
		end else if (do_rd) begin
			hold_valid_q <= is_low_byte(addr);
			hold_addr_q <= addr_p1;
			hold_q <= hold_next;
		end else if (do_wr) begin
			hold_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wbuf_q <= 8'h00;
			wbuf_addr_q <= 7'h00;
			wbuf_valid_q <= 1'b0;
		end else if (do_wr) begin
			wbuf_valid_q <= is_low_byte(addr);
			wbuf_addr_q <= addr_p1;
			wbuf_q <= wd;
		end else if (do_rd) begin
			wbuf_valid_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Write enables
	// ----------------------------------------
	// A failed check keeps its enable low, so the register holds
	wire we_phase = do_wr && addr == OFS_PHASE_HI && wr_top;
	wire we_fill = do_wr && addr == OFS_FILL_WIN;
	wire we_leak = do_wr && addr == OFS_LEAK_WIN;
	wire we_size = do_wr && addr == OFS_ACC_SIZE && size_ok;
	wire we_raise = do_wr && addr == OFS_RAISE_LVL && raise_ok;
	wire we_clear = do_wr && addr == OFS_CLEAR_LVL && clear_ok;
	wire we_trim = do_wr && addr == OFS_TRIM_HI && wr_top;
	wire we_reject = do_wr && addr == OFS_REJECT_HI && wr_top &&
		reject_ok;
	wire we_accept = do_wr && addr == OFS_ACCEPT_HI && wr_top &&
		accept_ok;
	wire we_soak = do_wr && addr == OFS_SOAK;
	wire we_ptr = do_wr && addr == OFS_REF_PTR && ptr_ok;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			phase_q <= RST_PHASE;
			trim_q <= RST_TRIM;
		end else begin
			if (we_phase) begin
				phase_q <= {wd, wbuf_q};
			end
			if (we_trim) begin
				trim_q <= {wd[2:0], wbuf_q};
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fill_q <= RST_FILL_WIN;
			leak_q <= RST_LEAK_WIN;
			size_q <= RST_ACC_SIZE;
			raise_q <= RST_RAISE_LVL;
			clear_q <= RST_CLEAR_LVL;
		end else begin
			if (we_fill) begin
				fill_q <= wd[3:0];
			end
			if (we_leak) begin
				leak_q <= wd[3:0];
			end
			if (we_size) begin
				size_q <= wd[5:0];
			end
			if (we_raise) begin
				raise_q <= wd[5:0];
			end
			if (we_clear) begin
				clear_q <= wd[5:0];
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reject_q <= RST_REJECT;
			accept_q <= RST_ACCEPT;
			soak_q <= RST_SOAK;
			ptr_q <= RST_REF_PTR;
		end else begin
			if (we_reject) begin
				reject_q <= wide10;
			end
			if (we_accept) begin
				accept_q <= wide10;
			end
			if (we_soak) begin
				soak_q <= wd[5:0];
			end
			if (we_ptr) begin
				ptr_q <= wd[3:0];
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign data_out = dout_q;
	assign data_oe_n = doe_n_q;
	assign ready_out = rdy_q;
	assign ready_oe_n = rdy_oe_n_q;
	assign slave_phase_offset = phase_q;
	assign fill_window_size = fill_q;
	assign leak_window_multiple = leak_q;
	assign activity_accumulator_size = size_q;
	assign accumulator_bypass = size_q == 6'h00;
	assign alarm_raise_level = raise_q;
	assign alarm_clear_level = clear_q;
	assign free_oscillator_trim = trim_q;
	assign reject_offset_limit = reject_q;
	assign accept_offset_limit = accept_q;
	assign accept_soak_seconds = soak_q;
	assign reference_pointer = ptr_q;

endmodule

// File: rtl/schrb_pkg.sv
// Package: register map, reset values, bus modes and host pin bundle
package schrb_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [6:0] OFS_IDENTITY_LO = 7'h00;
	localparam logic [6:0] OFS_IDENTITY_HI = 7'h01;
	localparam logic [6:0] OFS_SILICON_REV = 7'h02;
	localparam logic [6:0] OFS_FIRMWARE_REV = 7'h03;
	localparam logic [6:0] OFS_ROLE_STATUS = 7'h04;
	localparam logic [6:0] OFS_PHASE_LO = 7'h05;
	localparam logic [6:0] OFS_PHASE_HI = 7'h06;
	localparam logic [6:0] OFS_FILL_WIN = 7'h07;
	localparam logic [6:0] OFS_LEAK_WIN = 7'h08;
	localparam logic [6:0] OFS_ACC_SIZE = 7'h09;
	localparam logic [6:0] OFS_RAISE_LVL = 7'h0A;
	localparam logic [6:0] OFS_CLEAR_LVL = 7'h0B;
	localparam logic [6:0] OFS_TRIM_LO = 7'h0C;
	localparam logic [6:0] OFS_TRIM_HI = 7'h0D;
	localparam logic [6:0] OFS_REJECT_LO = 7'h0E;
	localparam logic [6:0] OFS_REJECT_HI = 7'h0F;
	localparam logic [6:0] OFS_ACCEPT_LO = 7'h10;
	localparam logic [6:0] OFS_ACCEPT_HI = 7'h11;
	localparam logic [6:0] OFS_SOAK = 7'h12;
	localparam logic [6:0] OFS_REF_PTR = 7'h13;
	localparam logic [6:0] OFS_REF_INFO_LO = 7'h14;
	localparam logic [6:0] OFS_REF_INFO_HI = 7'h15;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_PHASE = 16'h0000;
	localparam logic [3:0] RST_FILL_WIN = 4'h0;
	localparam logic [3:0] RST_LEAK_WIN = 4'h3;
	localparam logic [5:0] RST_ACC_SIZE = 6'h14;
	localparam logic [5:0] RST_RAISE_LVL = 6'h0F;
	localparam logic [5:0] RST_CLEAR_LVL = 6'h0A;
	localparam logic [10:0] RST_TRIM = 11'h000;
	localparam logic [9:0] RST_REJECT = 10'h06E;
	localparam logic [9:0] RST_ACCEPT = 10'h064;
	localparam logic [5:0] RST_SOAK = 6'h0A;
	localparam logic [3:0] RST_REF_PTR = 4'h1;

	// ----------------------------------------
	// Field limits and codes
	// ----------------------------------------
	localparam logic [3:0] REF_PTR_MIN = 4'h1;
	localparam logic [3:0] REF_PTR_MAX = 4'hC;
	localparam logic [11:0] OFFSET_OUT_OF_RANGE = 12'h800;
	localparam logic [3:0] RATE_MANUAL = 4'hF;
	localparam int REF_COUNT = 12;

	// ----------------------------------------
	// Timing: ready pulse length
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 10000;
	localparam int READY_TIME_PS = 50000;
	localparam int READY_CYCLES =
		(READY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------
	// Host bus modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SCHRB_MODE_RSVD = 3'b001,
		SCHRB_MODE_MUX = 3'b010,
		SCHRB_MODE_STROBE = 3'b011,
		SCHRB_MODE_RWLINE = 3'b100,
		SCHRB_MODE_SERIAL = 3'b101
	} schrb_mode_t;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic [6:0] addr;
		logic [7:0] data;
	} schrb_host_in_t;

	typedef struct packed {
		logic [3:0] rate;
		logic [11:0] offset;
	} schrb_ref_info_t;

endpackage

// File: tb/schrb_chk.sv
// Checker: bus handshake timing and config consistency of the bank
`timescale 1ns/1ps
module schrb_chk
	import schrb_pkg::*;
#(
	parameter int READY_LEN = 5
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [2:0] host_bus_select_pins,
	input wire schrb_pkg::schrb_host_in_t host_in,
	input wire logic data_oe_n,
	input wire logic ready_out,
	input wire logic ready_oe_n,
	input wire logic [5:0] activity_accumulator_size,
	input wire logic accumulator_bypass,
	input wire logic [5:0] alarm_raise_level,
	input wire logic [5:0] alarm_clear_level,
	input wire logic [9:0] reject_offset_limit,
	input wire logic [9:0] accept_offset_limit,
	input wire logic [3:0] reference_pointer
);
	localparam int LINE_WAIT = READY_LEN + 3;
	localparam int LOW_LAST = READY_LEN - 1;
	wire logic strb = host_bus_select_pins == SCHRB_MODE_STROBE ||
		host_bus_select_pins == SCHRB_MODE_MUX;
	wire logic line = host_bus_select_pins == SCHRB_MODE_RWLINE;
	wire logic go = !host_in.cs_n && !host_in.ale;

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	a_ready_drops: assert property (strb && go &&
		$fell(host_in.rd_n & host_in.wr_n) |=> !ready_out && !ready_oe_n)
		else $error("ready not pulled low after strobe");
	a_ready_span: assert property (strb && $fell(ready_out) |->
		!ready_out ##LOW_LAST !ready_out ##1 ready_out)
		else $error("ready low span wrong");
	a_read_drives: assert property (strb && go && $fell(host_in.rd_n)
		|=> ##1 !data_oe_n) else $error("read data not driven");
	a_line_up: assert property (line && $fell(host_in.cs_n)
		|=> ready_out && !ready_oe_n) else $error("line ready not raised");
	a_line_end: assert property (line && $fell(host_in.cs_n)
		|-> ##[1:LINE_WAIT] !ready_out) else $error("line ready never fell");
	a_ready_release: assert property ($rose(host_in.cs_n) |=> ready_oe_n)
		else $error("ready not released after select");
	a_bypass_zero: assert property (accumulator_bypass ==
		(activity_accumulator_size == 6'h00)) else $error("bypass wrong");
	a_levels_ordered: assert property (alarm_raise_level > alarm_clear_level
		&& alarm_raise_level <= activity_accumulator_size)
		else $error("alarm levels out of order");
	a_limits_ordered: assert property (reject_offset_limit >
		accept_offset_limit) else $error("offset limits out of order");
	a_ptr_range: assert property (reference_pointer inside {[1:12]})
		else $error("pointer out of range");
	a_reset_vals: assert property ($rose(resetn) |->
		reference_pointer == RST_REF_PTR && alarm_raise_level == RST_RAISE_LVL
		&& alarm_clear_level == RST_CLEAR_LVL
		&& activity_accumulator_size == RST_ACC_SIZE)
		else $error("config not at reset values");
endmodule

bind schrb_regbank schrb_chk #(.READY_LEN(READY_LEN)) chk_i (
	.clock(clock), .resetn(resetn),
	.host_bus_select_pins(host_bus_select_pins), .host_in(host_in),
	.data_oe_n(data_oe_n), .ready_out(ready_out), .ready_oe_n(ready_oe_n),
	.activity_accumulator_size(activity_accumulator_size),
	.accumulator_bypass(accumulator_bypass),
	.alarm_raise_level(alarm_raise_level),
	.alarm_clear_level(alarm_clear_level),
	.reject_offset_limit(reject_offset_limit),
	.accept_offset_limit(accept_offset_limit),
	.reference_pointer(reference_pointer));

// File: tb/schrb_host.sv
// Host processor model on the parallel register bus
`timescale 1ns/1ps
module schrb_host
	import schrb_pkg::*;
(
	input wire logic clock,
	input wire logic ready_out,
	input wire logic [7:0] data_out,
	output logic [2:0] mode_pins,
	output schrb_pkg::schrb_host_in_t host_in
);
	int stalls = 0;
	initial begin
		mode_pins = SCHRB_MODE_STROBE;
		host_in = '{1'b1, 1'b1, 1'b1, 1'b0, 7'h00, 8'h00};
	end
	// ----------------------------------------
	// One access, all changes at falling edges
	// ----------------------------------------
	task automatic acc(input logic [2:0] m, input logic w,
		input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(negedge clock);
		mode_pins = m;
		host_in.addr = a;
		host_in.data = d;
		if (m == SCHRB_MODE_MUX) begin
			host_in.addr = ~a;
			host_in.data = {1'b0, a};
			host_in.ale = 1'b1;
			@(negedge clock);
			host_in.ale = 1'b0;
			host_in.data = d;
		end
		host_in.cs_n = 1'b0;
		host_in.wr_n = !w;
		if (m != SCHRB_MODE_RWLINE) host_in.rd_n = w;
		// Strobe modes end on ready high, line mode on ready low
		do begin
			@(posedge clock);
			n++;
		end while ((n < 3 || ready_out !== (m != SCHRB_MODE_RWLINE))
			&& n < 40);
		if (n >= 40) stalls++;
		q = data_out;
		@(negedge clock);
		host_in.cs_n = 1'b1;
		host_in.rd_n = 1'b1;
		host_in.wr_n = 1'b1;
		// Released lines must not keep the last value
		host_in.data = ~host_in.data;
		repeat (5) @(negedge clock);
	endtask
endmodule

// File: tb/tb.sv
// Testbench: register map, multibyte access, range rules and bus modes
`timescale 1ns/1ps
module tb;
	import schrb_pkg::*;
	localparam logic [15:0] ID = 16'h3C96; // Arbitrary value
	localparam logic [7:0] SREV = 8'h5A; // Arbitrary value
	localparam logic [7:0] FREV = 8'hA7; // Arbitrary value
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic role = 1'b1;
	logic [REF_COUNT*16-1:0] refs = '0;
	logic [2:0] mode;
	schrb_host_in_t hin;
	logic [7:0] dout, q;
	logic rdy;
	logic [15:0] phase;
	logic [10:0] trim;
	logic [3:0] fillw, leakw, rptr;
	logic [5:0] soak;
	logic [2:0] bm = SCHRB_MODE_STROBE;
	int err_total = 0;
	int n_checks = 0;
	always #5 clock = ~clock;

	schrb_host host (.clock(clock), .ready_out(rdy), .data_out(dout),
		.mode_pins(mode), .host_in(hin));
	schrb_regbank #(.IDENTITY_CODE(ID), .SILICON_REV(SREV),
		.FIRMWARE_REV(FREV)) uut (.clock(clock), .resetn(resetn),
		.host_bus_select_pins(mode), .role_select_pin(role), .host_in(hin),
		.ref_info_flat(refs), .data_out(dout), .data_oe_n(), .ready_out(rdy),
		.ready_oe_n(), .slave_phase_offset(phase), .fill_window_size(fillw),
		.leak_window_multiple(leakw), .activity_accumulator_size(),
		.accumulator_bypass(), .alarm_raise_level(), .alarm_clear_level(),
		.free_oscillator_trim(trim), .reject_offset_limit(),
		.accept_offset_limit(), .accept_soak_seconds(soak),
		.reference_pointer(rptr));

	task automatic chk(string w, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", w, e, g);
			err_total++;
		end
	endtask
	task automatic wr(logic [6:0] a, logic [7:0] d);
		host.acc(bm, 1'b1, a, d, q);
	endtask
	task automatic rd(logic [6:0] a, logic [7:0] e, string w);
		host.acc(bm, 1'b0, a, 8'h00, q);
		chk(w, {8'h00, e}, {8'h00, q});
	endtask
	task automatic wr16(logic [6:0] a, logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 7'h01, d[15:8]);
	endtask
	task automatic rd16(logic [6:0] a, logic [15:0] e, string w);
		rd(a, e[7:0], w);
		rd(a + 7'h01, e[15:8], w);
	endtask

	task automatic t_reset();
		rd16(OFS_PHASE_LO, 16'h0000, "phase");
		rd(OFS_FILL_WIN, 8'h00, "fill");
		rd(OFS_LEAK_WIN, 8'h03, "leak");
		rd(OFS_ACC_SIZE, 8'h14, "size");
		rd(OFS_RAISE_LVL, 8'h0F, "raise");
		rd(OFS_CLEAR_LVL, 8'h0A, "clear");
		rd16(OFS_TRIM_LO, 16'h0000, "trim");
		rd16(OFS_REJECT_LO, 16'h006E, "reject");
		rd16(OFS_ACCEPT_LO, 16'h0064, "accept");
		rd(OFS_SOAK, 8'h0A, "soak");
		chk("soak port", 16'h000A, {10'h000, soak});
		rd(OFS_REF_PTR, 8'h01, "pointer");
		$display("test reset values done");
	endtask
	task automatic t_ident();
		rd16(OFS_IDENTITY_LO, ID, "identity");
		rd(OFS_SILICON_REV, SREV, "silicon rev");
		wr(OFS_FIRMWARE_REV, ~FREV);
		rd(OFS_FIRMWARE_REV, FREV, "firmware rev");
		rd(OFS_ROLE_STATUS, 8'h01, "role master");
		role = 1'b0;
		rd(OFS_ROLE_STATUS, 8'h00, "role slave");
		rd(7'h7F, 8'h00, "unmapped");
		$display("test identity done");
	endtask
	task automatic t_mbwrite();
		wr(OFS_PHASE_LO, 8'h34);
		chk("phase before top", 16'h0000, phase);
		wr(OFS_PHASE_HI, 8'hF2);
		chk("phase commit", 16'hF234, phase);
		wr(OFS_TRIM_LO, 8'h55);
		rd(OFS_SOAK, 8'h0A, "soak between");
		wr(OFS_TRIM_HI, 8'h07);
		chk("trim broken", 16'h0000, {5'h00, trim});
		wr16(OFS_TRIM_LO, 16'h0400);
		chk("trim min", 16'h0400, {5'h00, trim});
		wr(OFS_FILL_WIN, 8'h0F);
		chk("fill", 16'h000F, {12'h000, fillw});
		wr(OFS_LEAK_WIN, 8'h0F);
		chk("leak", 16'h000F, {12'h000, leakw});
		$display("test multibyte write done");
	endtask
	task automatic t_mbread();
		logic [7:0] bad [3] = '{8'h00, 8'h0D, 8'h1C};
		refs[11*16 +: 16] = {RATE_MANUAL, OFFSET_OUT_OF_RANGE};
		refs[15:0] = 16'h3F9C;
		wr(OFS_REF_PTR, 8'h0C);
		rd(OFS_REF_INFO_LO, 8'h00, "info low");
		refs[11*16 +: 16] = 16'h1234;
		rd(OFS_REF_INFO_HI, 8'hF8, "info snapshot");
		rd16(OFS_REF_INFO_LO, 16'h1234, "info fresh");
		foreach (bad[i]) wr(OFS_REF_PTR, bad[i]);
		rd(OFS_REF_PTR, 8'h0C, "pointer kept");
		chk("pointer port", 16'h000C, {12'h000, rptr});
		wr(OFS_REF_PTR, 8'h01);
		rd16(OFS_REF_INFO_LO, 16'h3F9C, "info ref1");
		$display("test multibyte read done");
	endtask
	task automatic t_ranges();
		wr(OFS_RAISE_LVL, 8'h0A);
		wr(OFS_RAISE_LVL, 8'h15);
		rd(OFS_RAISE_LVL, 8'h0F, "raise kept");
		wr(OFS_RAISE_LVL, 8'h14);
		rd(OFS_RAISE_LVL, 8'h14, "raise at size");
		wr(OFS_ACC_SIZE, 8'h13);
		rd(OFS_ACC_SIZE, 8'h14, "size kept");
		wr(OFS_CLEAR_LVL, 8'h14);
		rd(OFS_CLEAR_LVL, 8'h0A, "clear kept");
		wr(OFS_CLEAR_LVL, 8'h13);
		rd(OFS_CLEAR_LVL, 8'h13, "clear new");
		wr(OFS_ACC_SIZE, 8'h3F);
		rd(OFS_ACC_SIZE, 8'h3F, "size max");
		wr16(OFS_REJECT_LO, 16'h0064);
		rd16(OFS_REJECT_LO, 16'h006E, "reject kept");
		wr16(OFS_ACCEPT_LO, 16'h006E);
		rd16(OFS_ACCEPT_LO, 16'h0064, "accept kept");
		wr16(OFS_ACCEPT_LO, 16'h006D);
		wr16(OFS_REJECT_LO, 16'h03FF);
		rd16(OFS_REJECT_LO, 16'h03FF, "reject max");
		rd16(OFS_ACCEPT_LO, 16'h006D, "accept new");
		$display("test ranges done");
	endtask
	task automatic t_modes();
		logic [2:0] ms [3] = '{SCHRB_MODE_MUX, SCHRB_MODE_RWLINE,
			SCHRB_MODE_STROBE};
		for (int i = 0; i < 3; i++) begin
			bm = ms[i];
			wr(OFS_SOAK, 8'h30 | i[7:0]);
			rd(OFS_SOAK, 8'h30 | i[7:0], "soak by mode");
			rd16(OFS_IDENTITY_LO, ID, "identity by mode");
			wr16(OFS_PHASE_LO, 16'h8001 + i[15:0]);
			chk("phase by mode", 16'h8001 + i[15:0], phase);
		end
		$display("test bus modes done");
	endtask

	task automatic report_and_stop();
		err_total += host.stalls;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clock);
		resetn = 1'b1;
		t_reset();
		t_ident();
		t_mbwrite();
		t_mbread();
		t_ranges();
		t_modes();
		report_and_stop();
	end
	// About 100 accesses of some 15 cycles each, with wide margin
	initial begin
		#100us;
		err_total++;
		report_and_stop();
	end
endmodule
